// File: flash_host_model.sv
// host-side flash controller model driving select, clock and lanes
`timescale 1ns/100ps

module flash_host_model (
  // clock
  input wire logic core_clk,
  // flash link
  output logic flashCsN,
  output logic flashSclk,
  output logic [3:0] laneIn,
  input wire logic [3:0] laneOut,
  input wire logic [3:0] laneOe
);
  logic [3:0] hostOut = 4'h0;
  logic hostOe = 1'b0;
  logic sawOe = 1'b0;

  initial begin
    flashCsN = 1'b1;
    flashSclk = 1'b1;
  end
  // a released lane shows the inverse of its last level, never a stale copy
  assign laneIn = (laneOe & laneOut) | (~laneOe & hostOut);
  always @(posedge core_clk) begin
    if (laneOe != 4'h0) sawOe <= 1'b1;
  end

  // ==========================================================
  // one link clock: fall, four core clocks low, rise, four high
  task automatic tick(input logic [3:0] v, output logic [3:0] q);
    flashSclk <= 1'b0;
    if (hostOe) hostOut <= v;
    repeat (4) @(posedge core_clk);
    flashSclk <= 1'b1;
    repeat (3) @(posedge core_clk);
    q = laneOut;
    @(posedge core_clk);
  endtask

  // msb group first, on the highest lane of the group
  task automatic send(input logic [31:0] v, input int nb, input int w);
    logic [3:0] q;
    for (int c = nb - w; c >= 0; c -= w) tick(4'((v >> c) & ((1 << w) - 1)), q);
  endtask

  task automatic recv(input int w, output logic [7:0] b);
    logic [3:0] q;
    b = 8'h00;
    for (int j = 0; j < 8 / w; j++) begin
      tick(4'h0, q);
      b = (b << w) | 8'(q & 4'((1 << w) - 1));
    end
  endtask

  // lanes let go a core clock ahead of the next fall
  task automatic release_lanes();
    hostOe = 1'b0;
    hostOut <= ~hostOut;
    @(posedge core_clk);
  endtask

  task automatic open_frame();
    flashCsN <= 1'b0;
    hostOe = 1'b1;
    sawOe <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic close_frame();
    flashCsN <= 1'b1;
    hostOe = 1'b0;
    repeat (6) @(posedge core_clk);
  endtask
endmodule

// File: flash_read_pkg.sv
// constants and types shared by the multi-lane flash read path
package flash_read_pkg;

  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_QUAD_IO = 8'heb;
  localparam logic [7:0] OP_WORD_QUAD = 8'he7;

  // ==========================================================
  // frame layout
  localparam logic [4:0] OPCODE_BITS = 5'h08;
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [4:0] MODE_BITS = 5'h08;
  localparam logic [3:0] DUMMY_FAST = 4'h8;
  localparam logic [3:0] DUMMY_QUAD_IO = 4'h4;
  localparam logic [3:0] DUMMY_WORD = 4'h2;
  localparam logic [1:0] SKIP_CODE = 2'h2;
  localparam logic [23:0] WRAP_BASE_LEN = 24'h000008;
  localparam int MEM_DEPTH = 256;

  // ==========================================================
  // register map, byte addresses
  localparam logic [11:0] CFG_OFF = 12'h000;
  localparam logic [11:0] WRAP_OFF = 12'h004;
  localparam logic [11:0] STAT_OFF = 12'h008;
  localparam logic [11:0] MADDR_OFF = 12'h00c;
  localparam logic [11:0] MDATA_OFF = 12'h010;

  // ==========================================================
  // fields and reset values
  localparam int CFG_PERMIT_BIT = 0;
  localparam int CFG_QCM_BIT = 1;
  localparam int CFG_PARAM_LSB = 4;
  localparam int WRAP_LSB = 4;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [2:0] WRAP_RESET = 3'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_IGNORE
  } link_state_t;

endpackage

// File: multi_io_fast_read.sv
// multi-lane serial flash read path with AXI4-Lite configuration port
// Overview of operation
// RQ1 - dual output read drives lanes zero and one
// RQ2 - eight dummy clocks after address, inputs ignored
// RQ3 - host releases lanes before first data edge
// RQ4 - quad output read needs quad lane permit
// RQ5 - dual io read: address and data on two
// RQ6 - mode byte follows address; low nibble ignored
// RQ7 - skip code 10 arms opcode-less next read
// RQ8 - other skip codes require opcode next time
// RQ9 - host sends sixteen ones to leave dual
// RQ10 - host sends eight ones to leave quad
// RQ11 - quad io read: four lanes, four dummies
// RQ12 - quad io read needs quad lane permit
// RQ13 - wrap within aligned page section until deselect
// RQ14 - three wrap setting bits: disable, length
// RQ15 - quad command dummies 2/4/6/8, default 2
// RQ16 - quad command mode bits count as dummies
// RQ17 - opcode skipping works in quad command mode
// RQ18 - no wrap for quad io in quad mode
// RQ19 - word quad read uses two dummy clocks
// RQ20 - word quad read needs quad lane permit
// RQ21 - dual and quad output reads single-lane only
// RQ22 - address increments per byte until deselect
// RQ23 - wrap lengths 8, 16, 32, 64 bytes
// RQ24 - wrap disabled after reset
// RQ25 - single-lane opcode msb first on lane zero
// RQ26 - msb group on highest lane first
`timescale 1ns/100ps

module multi_io_fast_read import flash_read_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // axi4-lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // flash link pins
  input wire logic flashCsN,
  input wire logic flashSclk,
  input wire logic [3:0] laneIn,
  output logic [3:0] laneOut,
  output logic [3:0] laneOe
);

  // ==========================================================
  // helpers
  function automatic logic [23:0] shiftIn(input logic [23:0] acc, input logic [3:0] io,
                                          input logic [2:0] lanes);
    case (lanes)
      3'h1: shiftIn = {acc[22:0], io[0]};
      3'h2: shiftIn = {acc[21:0], io[1:0]};
      default: shiftIn = {acc[19:0], io};
    endcase
  endfunction

  function automatic logic [4:0] clocksFor(input logic [4:0] bits, input logic [2:0] lanes);
    case (lanes)
      3'h1: clocksFor = bits;
      3'h2: clocksFor = {1'b0, bits[4:1]};
      default: clocksFor = {2'b00, bits[4:2]};
    endcase
  endfunction

  function automatic logic [23:0] nextAddr(input logic [23:0] addr, input logic wrapOn,
                                           input logic [1:0] lenSel);
    logic [23:0] mask;
    mask = (WRAP_BASE_LEN << lenSel) - 24'h000001; // see RQ23
    if (wrapOn)
      nextAddr = (addr & ~mask) | ((addr + 24'h000001) & mask); // see RQ13
    else
      nextAddr = addr + 24'h000001; // see RQ22
  endfunction

  // ==========================================================
  // pin synchronisers
  logic csS1_reg, csS2_reg, sclkS1_reg, sclkS2_reg, sclkS3_reg;
  logic [3:0] ioS1_reg, ioS2_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      csS1_reg <= 1'b1;
      csS2_reg <= 1'b1;
      sclkS1_reg <= 1'b0;
      sclkS2_reg <= 1'b0;
      sclkS3_reg <= 1'b0;
      ioS1_reg <= 4'h0;
      ioS2_reg <= 4'h0;
    end else begin
      csS1_reg <= flashCsN;
      csS2_reg <= csS1_reg;
      sclkS1_reg <= flashSclk;
      sclkS2_reg <= sclkS1_reg;
      sclkS3_reg <= sclkS2_reg;
      ioS1_reg <= laneIn;
      ioS2_reg <= ioS1_reg;
    end
  end

  wire csHigh = csS2_reg;
  wire sclkRise = sclkS2_reg & ~sclkS3_reg;
  wire sclkFall = ~sclkS2_reg & sclkS3_reg;

  // ==========================================================
  // configuration state
  logic [7:0] cfg_reg;
  logic [2:0] wrap_reg;
  logic [7:0] memAddr_reg;
  logic [7:0] mem [0:MEM_DEPTH-1];

  wire quadLanePermit = cfg_reg[CFG_PERMIT_BIT];
  wire quadCommandMode = cfg_reg[CFG_QCM_BIT];
  wire [1:0] readParam = cfg_reg[CFG_PARAM_LSB +: 2];
  wire wrapDisableBit = wrap_reg[0];
  wire [1:0] wrapLengthSel = wrap_reg[2:1];

  // ==========================================================
  // link sequencer state
  link_state_t state_reg;
  logic [4:0] phaseCnt_reg, phaseLen_reg;
  logic [23:0] acc_reg, addr_reg;
  logic [7:0] opcode_reg;
  logic [2:0] addrLanes_reg, dataLanes_reg;
  logic hasMode_reg, wrapOk_reg, contFlag_reg;
  logic [3:0] dummy_reg;
  logic [1:0] skipCode_reg;
  logic [7:0] shReg_reg;
  logic [1:0] grpCnt_reg;

  wire [2:0] cmdLanes = quadCommandMode ? 3'h4 : 3'h1; // see RQ25
  wire [23:0] accNext = shiftIn(acc_reg, ioS2_reg, (state_reg == ST_OPCODE) ? cmdLanes
                                                                       : addrLanes_reg);
  wire phaseLast = (phaseCnt_reg == phaseLen_reg - 5'h01);
  wire [7:0] opNext = accNext[7:0];
  wire [7:0] modeNext = accNext[7:0];

  // ==========================================================
  // opcode decode
  logic decAccept, decMode, decWrap;
  logic [2:0] decAddrLanes, decDataLanes;
  logic [3:0] decDummy;

  always_comb begin
    decAccept = 1'b0;
    decMode = 1'b0;
    decWrap = 1'b0;
    decAddrLanes = 3'h1;
    decDataLanes = 3'h1;
    decDummy = 4'h0;
    case (opNext)
      OP_DUAL_OUT: begin
        decAccept = ~quadCommandMode; // see RQ21
        decDataLanes = 3'h2; // see RQ1
        decDummy = DUMMY_FAST; // see RQ2
      end
      OP_QUAD_OUT: begin
        decAccept = ~quadCommandMode & quadLanePermit; // see RQ4, RQ21
        decDataLanes = 3'h4;
        decDummy = DUMMY_FAST; // see RQ2
      end
      OP_DUAL_IO: begin
        decAccept = ~quadCommandMode; // see RQ21
        decAddrLanes = 3'h2; // see RQ5
        decDataLanes = 3'h2;
        decMode = 1'b1; // see RQ6
      end
      OP_QUAD_IO: begin
        decAccept = quadLanePermit; // see RQ12
        decAddrLanes = 3'h4; // see RQ11
        decDataLanes = 3'h4;
        decMode = 1'b1;
        // mode clocks already cover two of the programmed dummies
        decDummy = quadCommandMode ? {1'b0, readParam, 1'b0} : DUMMY_QUAD_IO; // see RQ15, RQ16
        decWrap = ~quadCommandMode; // see RQ18
      end
      OP_WORD_QUAD: begin
        decAccept = quadLanePermit & ~quadCommandMode; // see RQ20
        decAddrLanes = 3'h4;
        decDataLanes = 3'h4;
        decMode = 1'b1;
        decDummy = DUMMY_WORD; // see RQ19
        decWrap = 1'b1;
      end
      default: decAccept = 1'b0;
    endcase
  end

  // ==========================================================
  // sequencer
  wire byteDone = sclkFall && (state_reg == ST_DATA) &&
                  (grpCnt_reg == ((dataLanes_reg == 3'h2) ? 2'h3 : 2'h1));
  wire wrapActive = wrapOk_reg & ~wrapDisableBit;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      phaseCnt_reg <= 5'h00;
      phaseLen_reg <= OPCODE_BITS;
      acc_reg <= 24'h000000;
      addr_reg <= 24'h000000;
      opcode_reg <= 8'h00;
      addrLanes_reg <= 3'h1;
      dataLanes_reg <= 3'h1;
      hasMode_reg <= 1'b0;
      wrapOk_reg <= 1'b0;
      dummy_reg <= 4'h0;
      contFlag_reg <= 1'b0;
      skipCode_reg <= 2'h0;
    end else if (csHigh) begin
      // read attributes survive deselect for the opcode-less follow-up
      state_reg <= ST_IDLE;
      phaseCnt_reg <= 5'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          acc_reg <= 24'h000000;
          phaseCnt_reg <= 5'h00;
          if (contFlag_reg) begin
            state_reg <= ST_ADDR; // see RQ7, RQ17
            phaseLen_reg <= clocksFor(ADDR_BITS, addrLanes_reg);
          end else begin
            state_reg <= ST_OPCODE; // see RQ8
            phaseLen_reg <= clocksFor(OPCODE_BITS, cmdLanes);
          end
        end
        ST_OPCODE: if (sclkRise) begin
          acc_reg <= accNext;
          phaseCnt_reg <= phaseCnt_reg + 5'h01;
          if (phaseLast) begin
            opcode_reg <= opNext;
            phaseCnt_reg <= 5'h00;
            acc_reg <= 24'h000000;
            if (decAccept) begin
              state_reg <= ST_ADDR;
              phaseLen_reg <= clocksFor(ADDR_BITS, decAddrLanes);
              addrLanes_reg <= decAddrLanes;
              dataLanes_reg <= decDataLanes;
              hasMode_reg <= decMode;
              wrapOk_reg <= decWrap;
              dummy_reg <= decDummy;
            end else begin
              state_reg <= ST_IGNORE; // see RQ4
            end
          end
        end
        ST_ADDR: if (sclkRise) begin
          acc_reg <= accNext; // see RQ5
          phaseCnt_reg <= phaseCnt_reg + 5'h01;
          if (phaseLast) begin
            addr_reg <= accNext;
            phaseCnt_reg <= 5'h00;
            acc_reg <= 24'h000000;
            if (hasMode_reg) begin
              state_reg <= ST_MODE;
              phaseLen_reg <= clocksFor(MODE_BITS, addrLanes_reg);
            end else if (dummy_reg != 4'h0) begin
              state_reg <= ST_DUMMY;
              phaseLen_reg <= {1'b0, dummy_reg};
            end else begin
              state_reg <= ST_DATA;
            end
          end
        end
        ST_MODE: if (sclkRise) begin
          acc_reg <= accNext;
          phaseCnt_reg <= phaseCnt_reg + 5'h01;
          if (phaseLast) begin
            phaseCnt_reg <= 5'h00;
            skipCode_reg <= modeNext[5:4]; // see RQ6
            contFlag_reg <= (modeNext[5:4] == SKIP_CODE); // see RQ7, RQ8
            if (dummy_reg != 4'h0) begin
              state_reg <= ST_DUMMY;
              phaseLen_reg <= {1'b0, dummy_reg};
            end else begin
              state_reg <= ST_DATA; // see RQ16
            end
          end
        end
        ST_DUMMY: if (sclkRise) begin
          // lane values are not looked at here
          phaseCnt_reg <= phaseCnt_reg + 5'h01; // see RQ2
          if (phaseLast) begin
            phaseCnt_reg <= 5'h00;
            state_reg <= ST_DATA;
          end
        end
        ST_DATA: if (byteDone) begin
          addr_reg <= nextAddr(addr_reg, wrapActive, wrapLengthSel); // see RQ22
        end
        default: state_reg <= ST_IGNORE;
      endcase
    end
  end

  // ==========================================================
  // data output, changes on falling clock edges
  wire [7:0] curByte = (grpCnt_reg == 2'h0) ? mem[addr_reg[7:0]] : shReg_reg;

  always_ff @(posedge core_clk) begin
    if (rst || csHigh || state_reg != ST_DATA) begin
      laneOut <= 4'h0;
      laneOe <= 4'h0;
      shReg_reg <= 8'h00;
      grpCnt_reg <= 2'h0;
    end else if (sclkFall) begin
      // lanes are only taken after the first data falling edge
      if (dataLanes_reg == 3'h2) begin
        laneOut <= {2'b00, curByte[7:6]}; // see RQ1, RQ26
        laneOe <= 4'h3; // see RQ3
        shReg_reg <= {curByte[5:0], 2'b00};
      end else begin
        laneOut <= curByte[7:4]; // see RQ26
        laneOe <= 4'hf; // see RQ3
        shReg_reg <= {curByte[3:0], 4'h0};
      end
      grpCnt_reg <= byteDone ? 2'h0 : grpCnt_reg + 2'h1;
    end
  end

  // ==========================================================
  // axi4-lite write path
  logic awHeld_reg, wHeld_reg;
  logic [11:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;

  assign s_axi_awready = ~awHeld_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld_reg & ~s_axi_bvalid;

  wire doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
  wire wrLow = doWrite & wStrb_reg[0];
  wire wrCfg = wrLow && (awAddr_reg == CFG_OFF);
  wire wrWrap = wrLow && (awAddr_reg == WRAP_OFF);
  wire wrMaddr = wrLow && (awAddr_reg == MADDR_OFF);
  wire wrMdata = wrLow && (awAddr_reg == MDATA_OFF);
  wire wrKnown = (awAddr_reg == CFG_OFF) || (awAddr_reg == WRAP_OFF) ||
                 (awAddr_reg == STAT_OFF) || (awAddr_reg == MADDR_OFF) ||
                 (awAddr_reg == MDATA_OFF);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 12'h000;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrKnown ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_reg <= CFG_RESET; // see RQ15
      wrap_reg <= WRAP_RESET; // see RQ24
      memAddr_reg <= 8'h00;
    end else begin
      if (wrCfg)
        cfg_reg <= wData_reg[7:0];
      if (wrWrap)
        wrap_reg <= wData_reg[WRAP_LSB +: 3]; // see RQ14
      if (wrMaddr)
        memAddr_reg <= wData_reg[7:0];
      else if (wrMdata)
        memAddr_reg <= memAddr_reg + 8'h01;
    end
  end

  // array is not reset; contents are whatever software loaded
  always_ff @(posedge core_clk) begin
    if (wrMdata)
      mem[memAddr_reg] <= wData_reg[7:0];
  end

  // ==========================================================
  // axi4-lite read path
  logic [31:0] rdMux;
  logic rdKnown;
  wire [11:0] rdAddr = {s_axi_araddr[11:2], 2'b00};

  always_comb begin
    rdMux = 32'h00000000;
    rdKnown = 1'b1;
    if (rdAddr == CFG_OFF)
      rdMux = {24'h000000, cfg_reg};
    else if (rdAddr == WRAP_OFF)
      rdMux = {25'h0000000, wrap_reg, 4'h0};
    else if (rdAddr == STAT_OFF)
      rdMux = {14'h0000, skipCode_reg, opcode_reg, 4'h0, contFlag_reg, state_reg};
    else if (rdAddr == MADDR_OFF)
      rdMux = {24'h000000, memAddr_reg};
    else if (rdAddr == MDATA_OFF)
      rdMux = {24'h000000, mem[memAddr_reg]};
    else
      rdKnown = 1'b0;
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdKnown ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// File: multi_io_fast_read_assertions.sv
// port-level checks on the multi-lane flash read path
`timescale 1ns/100ps

module multi_io_fast_read_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // axi4-lite
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // flash link
  input wire logic flashCsN,
  input wire logic flashSclk,
  input wire logic [3:0] laneOut,
  input wire logic [3:0] laneOe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // ==========================================================
  // sequences
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_deselected;
    flashCsN [*5];
  endsequence

  // ==========================================================
  // properties
  property p_wr_answer;
    s_wr_taken |-> ##[1:2] s_axi_bvalid;
  endproperty
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_b_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_r_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_r_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  // sync delay means the lanes may stay driven a few cycles past deselect
  property p_deselect_quiet;
    s_deselected |-> laneOe == 4'h0;
  endproperty
  property p_oe_shape;
    laneOe inside {4'h0, 4'h3, 4'hf};
  endproperty
  property p_out_after_fall;
    $changed(laneOut) && laneOe != 4'h0 && !flashCsN && !$past(flashCsN, 3)
      |-> !$past(flashSclk, 3) || !$past(flashSclk, 4) || !$past(flashSclk, 5);
  endproperty

  // ==========================================================
  // assertions
  a_wr_answer: assert property (p_wr_answer) else $error("write response missing");
  a_rd_answer: assert property (p_rd_answer) else $error("read response missing");
  a_b_block: assert property (p_b_block) else $error("write taken during response");
  a_r_block: assert property (p_r_block) else $error("read taken during response");
  a_b_once: assert property (p_b_once) else $error("write response repeated");
  a_r_once: assert property (p_r_once) else $error("read response repeated");
  a_deselect_quiet: assert property (p_deselect_quiet) else $error("lanes driven");
  a_oe_shape: assert property (p_oe_shape) else $error("bad lane enable");
  a_out_after_fall: assert property (p_out_after_fall) else $error("data off fall");
endmodule

// File: multi_io_fast_read_bench.sv
// self-checking bench for the multi-lane flash read path
`timescale 1ns/100ps

module multi_io_fast_read_bench import flash_read_pkg::*;;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  wire logic flashCsN;
  wire logic flashSclk;
  wire logic [3:0] laneIn;
  logic [3:0] laneOut;
  logic [3:0] laneOe;
  int n_fail = 0;
  int checks = 0;
  logic [1:0] r;
  logic [31:0] d;
  logic [7:0] qops [3] = '{OP_QUAD_OUT, OP_QUAD_IO, OP_WORD_QUAD};
  logic [7:0] sops [3] = '{OP_DUAL_OUT, OP_QUAD_OUT, OP_DUAL_IO};

  always #10 core_clk = ~core_clk;

  multi_io_fast_read dut_u (
    .core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .flashCsN, .flashSclk, .laneIn, .laneOut, .laneOe
  );
  flash_host_model host_u (.core_clk, .flashCsN, .flashSclk, .laneIn, .laneOut, .laneOe);

  // ==========================================================
  // helpers
  function automatic logic [7:0] mv(input logic [7:0] i);
    return {i[3:0], i[7:4]} ^ 8'h3c;
  endfunction

  task automatic finish_test(input bit hung);
    if (hung) n_fail++;
    if (n_fail == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    int i;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (i == 40) finish_test(1'b1);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    int i;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (i == 40) finish_test(1'b1);
  endtask

  // ow or mw of zero leaves that phase out; wm masks the wrap section
  task automatic frame(input logic [7:0] op, input int ow, input logic [23:0] a, input int aw,
      input int mw, input logic [7:0] m, input int dum, input int dw, input logic [7:0] wm,
      input bit ok);
    logic [7:0] b;
    logic [7:0] idx;
    host_u.open_frame();
    if (ow != 0) host_u.send(32'(op), 8, ow);
    host_u.send(32'(a), 24, aw);
    if (mw != 0) host_u.send(32'(m), 8, mw);
    host_u.release_lanes();
    host_u.send(32'h0, dum, 1);
    for (int k = 0; k < 4; k++) begin
      host_u.recv(dw, b);
      idx = (a[7:0] & ~wm) | ((a[7:0] + 8'(k)) & wm);
      if (ok) chk(32'(b), 32'(mv(idx)));
    end
    if (!ok) chk(32'(host_u.sawOe), 32'h0);
    host_u.close_frame();
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs();
    rd(CFG_OFF, d, r);
    chk(d, 32'h0);
    rd(WRAP_OFF, d, r);
    chk(d, 32'h10);
    wr(WRAP_OFF, 32'h70, r);
    chk(32'(r), 32'(RESP_OKAY));
    rd(WRAP_OFF, d, r);
    chk(d, 32'h70);
    chk(32'(r), 32'(RESP_OKAY));
    wr(12'h020, 32'h1, r);
    chk(32'(r), 32'(RESP_SLVERR));
    rd(12'h020, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    wr(MADDR_OFF, 32'h0, r);
    for (int i = 0; i < MEM_DEPTH; i++) wr(MDATA_OFF, 32'(mv(8'(i))), r);
  endtask

  task automatic t_single();
    frame(OP_DUAL_OUT, 1, 24'h0000fd, 1, 0, 8'h00, 8, 2, 8'hff, 1'b1);
    foreach (qops[i]) frame(qops[i], 1, 24'h10, 4, 4, 8'h0, 4, 4, 8'hff, 1'b0);
    wr(CFG_OFF, 32'h1, r);
    frame(OP_QUAD_OUT, 1, 24'h000021, 1, 0, 8'h00, 8, 4, 8'hff, 1'b1);
  endtask

  task automatic t_dual_io();
    frame(OP_DUAL_IO, 1, 24'h000040, 2, 2, 8'h2f, 0, 2, 8'hff, 1'b1);
    rd(STAT_OFF, d, r);
    chk(d, 32'h0002bb08);
    frame(OP_DUAL_IO, 0, 24'h000080, 2, 2, 8'h10, 0, 2, 8'hff, 1'b1);
    frame(OP_DUAL_IO, 1, 24'h0000c0, 2, 2, 8'h20, 0, 2, 8'hff, 1'b1);
    // sixteen clocks of ones on lane zero force the exit; next frame needs an opcode
    frame(OP_DUAL_IO, 0, 24'h555555, 2, 2, 8'h55, 0, 2, 8'hff, 1'b1);
  endtask

  task automatic t_wrap();
    for (int s = 0; s < 4; s++) begin
      wr(WRAP_OFF, 32'(s) << 5, r);
      frame(OP_QUAD_IO, 1, 24'h80 + 24'((8 << s) - 2), 4, 4, 8'h00, 4, 4,
        8'((8 << s) - 1), 1'b1);
    end
    frame(OP_WORD_QUAD, 1, 24'h0000be, 4, 4, 8'h00, 2, 4, 8'h3f, 1'b1);
  endtask

  // wrap stays enabled here, so a wrapped stream would show up as a mismatch
  task automatic t_qcm();
    for (int p = 0; p < 4; p++) begin
      wr(CFG_OFF, 32'h3 | (32'(p) << 4), r);
      frame(OP_QUAD_IO, 4, 24'h3e, 4, 4, 8'h0, 2 * p, 4, 8'hff, 1'b1);
    end
    frame(OP_QUAD_IO, 4, 24'h000050, 4, 4, 8'ha0, 6, 4, 8'hff, 1'b1);
    frame(OP_QUAD_IO, 0, 24'h111111, 4, 4, 8'h11, 6, 4, 8'hff, 1'b1);
    foreach (sops[i]) frame(sops[i], 4, 24'h10, 1, 0, 8'h0, 8, 2, 8'hff, 1'b0);
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_single();
    t_dual_io();
    t_wrap();
    t_qcm();
    finish_test(1'b0);
  end
endmodule

bind multi_io_fast_read multi_io_fast_read_assertions chk_u (
  .core_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .flashCsN, .flashSclk, .laneOut, .laneOe
);
